// ---- mfc_pkg.sv ----
package mfc_pkg;
    // --------------------------------------------------------------
    // check arithmetic
    // --------------------------------------------------------------
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [7:0] LRC_ONES = 8'hFF;
    localparam logic [7:0] LRC_ONE = 8'h01;
    localparam logic [3:0] BIT_STEPS = 4'h8;
    localparam logic [3:0] STEP_ZERO = 4'h0;
    localparam logic [3:0] STEP_ONE = 4'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] NIB_TEN = 4'hA;
    localparam logic [7:0] ASCII_ZERO = 8'h30;
    localparam logic [7:0] ASCII_ALPHA = 8'h37;
    // --------------------------------------------------------------
    // frame layouts
    // --------------------------------------------------------------
    localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
    localparam logic [7:0] FC_REPORT_ID = 8'h11;
    localparam logic [7:0] ID_REPLY_BYTES = 8'h1A; // 2+2+2+20
    localparam logic [7:0] ID_NAME_BYTES = 8'h14;
    localparam logic [7:0] WRM_HDR_BYTES = 8'h07;
    localparam logic [7:0] WRM_ECHO_BYTES = 8'h06;
    localparam logic [7:0] POS_FUNC = 8'h01;
    localparam logic [7:0] POS_BYTE_COUNT = 8'h06;
    localparam logic [7:0] ID_REQ_BYTES = 8'h02;
    localparam logic [7:0] CNT_STEP = 8'h01;
    // --------------------------------------------------------------
    // tail sequencing
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        MFC_IDLE = 2'b00,
        MFC_FIRST = 2'b01,
        MFC_SECOND = 2'b11
    } mfc_tail_t;
endpackage : mfc_pkg

// ---- mfc_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface mfc_if;
    logic [7:0] data; // byte on the serial link
    logic valid; // byte strobe
    logic sof; // message start, presets checks
    logic tail; // byte belongs to check field
    logic eof; // message end
    modport dev (input data, valid, sof, tail, eof);
    modport mst (output data, valid, sof, tail, eof);
endinterface : mfc_if
`default_nettype wire

// ---- mfc_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
module mfc_dev
    import mfc_pkg::*;
(
    input wire logic SYS_CLK, // byte clock
    input wire logic RST_N, // sync reset
    mfc_if.dev LINK, // received frame from master
    input wire logic ASCII_MODE, // 1 lrc framing, 0 crc framing
    input wire logic CLR, // restore preset
    output logic BUSY, // crc stepping
    output logic [15:0] CRC_OUT, // running crc
    output logic [7:0] LRC_OUT, // running lrc (negated)
    output logic CHK_DONE, // pulse, check compared
    output logic CHK_ERR, // pulse with done on mismatch
    output logic [7:0] FUNC, // function code seen
    output logic FRAME_OK // layout matches function
);
    logic [15:0] crc_ff;
    logic [3:0] step_ff;
    logic [7:0] sum_ff;
    logic [7:0] rx_lo_ff;
    logic [7:0] nib_ff;
    logic [7:0] cnt_ff;
    logic [7:0] func_ff;
    logic [7:0] bc_ff;
    logic done_ff;
    logic err_ff;
    logic ok_ff;
    mfc_tail_t tail_ff;
    logic [15:0] nxt_crc;
    logic [15:0] snap_crc_ff;
    logic [7:0] snap_lrc_ff;
    logic [7:0] lrc_val;
    logic [15:0] base_crc;
    logic [7:0] nxt_sum;
    logic [7:0] lrc_ff;
    logic take;

    // the eof beat carries no body data and must stay out of both engines
    assign take = LINK.valid && !LINK.tail && !LINK.eof;
    assign lrc_val = lrc_ff;
    assign BUSY = (step_ff != STEP_ZERO);

    // --------------------------------------------------------------
    // crc engine
    // --------------------------------------------------------------
    always_comb begin
        // first byte of a message folds into a fresh preset
        base_crc = LINK.sof ? CRC_PRESET : crc_ff;
        nxt_crc = crc_ff;
        if (take) begin
            nxt_crc = {base_crc[15:8], base_crc[7:0] ^ LINK.data};
        end else if (BUSY) begin
            // one shift per clock while stepping
            nxt_crc = {1'b0, crc_ff[15:1]};
            if (crc_ff[0]) begin
                nxt_crc = nxt_crc ^ CRC_POLY;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || CLR) begin
            crc_ff <= CRC_PRESET;
            step_ff <= STEP_ZERO;
        end else begin
            crc_ff <= nxt_crc;
            if (take) begin
                // a body-byte strobe (not tail or eof) restarts the eight-step count
                step_ff <= BIT_STEPS;
            end else if (BUSY) begin
                step_ff <= step_ff - STEP_ONE;
            end
        end
    end

    // --------------------------------------------------------------
    // lrc engine
    // --------------------------------------------------------------
    always_comb begin
        nxt_sum = sum_ff;
        if (take && ASCII_MODE) begin
            nxt_sum = (LINK.sof ? BYTE_ZERO : sum_ff) + LINK.data;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || CLR) begin
            sum_ff <= BYTE_ZERO;
            lrc_ff <= BYTE_ZERO;
        end else begin
            sum_ff <= nxt_sum;
            // registered negation keeps the output off the adder chain
            lrc_ff <= 8'(LRC_ONES - nxt_sum) + LRC_ONE;
        end
    end

    // --------------------------------------------------------------
    // check field compare
    // --------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || CLR) begin
            tail_ff <= MFC_IDLE;
            rx_lo_ff <= BYTE_ZERO;
            nib_ff <= BYTE_ZERO;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
            snap_crc_ff <= CRC_PRESET;
            snap_lrc_ff <= BYTE_ZERO;
        end else begin
            done_ff <= 1'b0;
            err_ff <= 1'b0;
            if (LINK.valid && LINK.tail) begin
                case (tail_ff)
                    MFC_IDLE: begin
                        // first check byte freezes both engines
                        tail_ff <= MFC_SECOND;
                        rx_lo_ff <= LINK.data;
                        nib_ff <= hex_val(LINK.data);
                        snap_crc_ff <= crc_ff;
                        snap_lrc_ff <= lrc_val;
                    end
                    default: begin
                        tail_ff <= MFC_IDLE;
                        done_ff <= 1'b1;
                        if (ASCII_MODE) begin
                            // high char then low char
                            err_ff <= ({nib_ff[3:0], hex_nib(LINK.data)} != snap_lrc_ff);
                        end else begin
                            // low byte first
                            err_ff <= ({LINK.data, rx_lo_ff} != snap_crc_ff);
                        end
                    end
                endcase
            end
        end
    end

    // --------------------------------------------------------------
    // hex character decode
    // --------------------------------------------------------------
    function automatic logic [7:0] hex_val(input logic [7:0] c);
        hex_val = {4'h0, hex_nib(c)};
    endfunction : hex_val

    function automatic logic [3:0] hex_nib(input logic [7:0] c);
        // upper- and lower-case hex both decode cleanly, only the low nibble is kept
        if (c >= ASCII_ALPHA + {4'h0, NIB_TEN}) begin
            hex_nib = 4'(c - ASCII_ALPHA);
        end else begin
            hex_nib = 4'(c - ASCII_ZERO);
        end
    endfunction : hex_nib

    // --------------------------------------------------------------
    // frame layout tracking
    // --------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || CLR) begin
            cnt_ff <= BYTE_ZERO;
            func_ff <= BYTE_ZERO;
            bc_ff <= BYTE_ZERO;
            ok_ff <= 1'b0;
        end else if (LINK.valid && LINK.sof) begin
            cnt_ff <= CNT_STEP;
            ok_ff <= 1'b0;
        end else if (take) begin
            cnt_ff <= cnt_ff + CNT_STEP;
            if (cnt_ff == POS_FUNC) begin
                func_ff <= LINK.data;
            end
            if (cnt_ff == POS_BYTE_COUNT) begin
                bc_ff <= LINK.data;
            end
        end else if (LINK.valid && LINK.eof) begin
            // layout judged once the check field has passed
            if (func_ff == FC_WRITE_MULTI) begin
                ok_ff <= (cnt_ff == WRM_HDR_BYTES + bc_ff);
            end else if (func_ff == FC_REPORT_ID) begin
                ok_ff <= (cnt_ff == ID_REQ_BYTES);
            end else begin
                ok_ff <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign CRC_OUT = crc_ff;
    assign LRC_OUT = lrc_val;
    assign CHK_DONE = done_ff;
    assign CHK_ERR = err_ff;
    assign FUNC = func_ff;
    assign FRAME_OK = ok_ff;
endmodule : mfc_dev
`default_nettype wire

// ---- mfc_mst.sv ----
`timescale 1ns/1ps
`default_nettype none
module mfc_mst
    import mfc_pkg::*;
(
    input wire logic SYS_CLK, // byte clock
    input wire logic RST_N, // sync reset
    mfc_if.mst LINK, // frame toward device
    input wire logic ASCII_MODE, // 1 lrc, 0 crc
    input wire logic IN_VALID, // body byte offered
    input wire logic [7:0] IN_DATA, // body byte
    input wire logic IN_SOF, // first body byte
    input wire logic IN_LAST, // last body byte, append check
    output logic IN_READY, // byte accepted this cycle
    output logic [15:0] CRC_OUT // running crc
);
    logic [15:0] crc_ff;
    logic [3:0] step_ff;
    logic [7:0] sum_ff;
    logic [7:0] data_ff;
    logic valid_ff;
    logic sof_ff;
    logic tail_ff;
    logic eof_ff;
    mfc_tail_t state_ff;
    logic [15:0] nxt_crc;
    logic [7:0] lrc_val;
    logic last_ff;

    // --------------------------------------------------------------
    // check generation
    // --------------------------------------------------------------
    assign IN_READY = (step_ff == STEP_ZERO) && (state_ff == MFC_IDLE) && !last_ff;
    assign lrc_val = 8'(LRC_ONES - sum_ff) + LRC_ONE;

    always_comb begin
        nxt_crc = crc_ff;
        if (IN_VALID && IN_READY) begin
            nxt_crc = {(IN_SOF ? CRC_PRESET[15:8] : crc_ff[15:8]),
                       (IN_SOF ? CRC_PRESET[7:0] : crc_ff[7:0]) ^ IN_DATA};
        end else if (step_ff != STEP_ZERO) begin
            nxt_crc = {1'b0, crc_ff[15:1]} ^ (crc_ff[0] ? CRC_POLY : 16'h0000);
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            crc_ff <= CRC_PRESET;
            step_ff <= STEP_ZERO;
            sum_ff <= BYTE_ZERO;
        end else begin
            crc_ff <= nxt_crc;
            if (IN_VALID && IN_READY) begin
                step_ff <= BIT_STEPS;
                sum_ff <= (IN_SOF ? BYTE_ZERO : sum_ff) + IN_DATA;
            end else if (step_ff != STEP_ZERO) begin
                step_ff <= step_ff - STEP_ONE;
            end
        end
    end

    // --------------------------------------------------------------
    // link output
    // --------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_ff <= MFC_IDLE;
            last_ff <= 1'b0;
            data_ff <= BYTE_ZERO;
            valid_ff <= 1'b0;
            sof_ff <= 1'b0;
            tail_ff <= 1'b0;
            eof_ff <= 1'b0;
        end else begin
            valid_ff <= 1'b0;
            sof_ff <= 1'b0;
            tail_ff <= 1'b0;
            eof_ff <= 1'b0;
            if (IN_VALID && IN_READY) begin
                valid_ff <= 1'b1;
                data_ff <= IN_DATA;
                sof_ff <= IN_SOF;
                last_ff <= IN_LAST;
            end else if (last_ff && step_ff == STEP_ZERO) begin
                case (state_ff)
                    MFC_IDLE: begin
                        state_ff <= MFC_FIRST;
                        valid_ff <= 1'b1;
                        tail_ff <= 1'b1;
                        data_ff <= ASCII_MODE ? hex_chr(lrc_val[7:4]) : crc_ff[7:0];
                    end
                    MFC_FIRST: begin
                        state_ff <= MFC_SECOND;
                        valid_ff <= 1'b1;
                        tail_ff <= 1'b1;
                        data_ff <= ASCII_MODE ? hex_chr(lrc_val[3:0]) : crc_ff[15:8];
                    end
                    default: begin
                        state_ff <= MFC_IDLE;
                        last_ff <= 1'b0;
                        valid_ff <= 1'b1;
                        eof_ff <= 1'b1;
                    end
                endcase
            end
        end
    end

    function automatic logic [7:0] hex_chr(input logic [3:0] n);
        hex_chr = (n >= NIB_TEN) ? (ASCII_ALPHA + {4'h0, n}) : (ASCII_ZERO + {4'h0, n});
    endfunction : hex_chr

    assign LINK.data = data_ff;
    assign LINK.valid = valid_ff;
    assign LINK.sof = sof_ff;
    assign LINK.tail = tail_ff;
    assign LINK.eof = eof_ff;
    assign CRC_OUT = crc_ff;
endmodule : mfc_mst
`default_nettype wire

// ---- mfc_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module mfc_assertions
    import mfc_pkg::*;
(
    input wire logic SYS_CLK, // clock
    input wire logic RST_N, // sync reset
    input wire logic [7:0] data, // link byte
    input wire logic valid, // link strobe
    input wire logic sof, // link start
    input wire logic tail, // link check byte
    input wire logic eof, // link end
    input wire logic ASCII_MODE, // lrc framing
    input wire logic CLR, // preset request
    input wire logic BUSY, // crc stepping
    input wire logic [15:0] CRC_OUT, // running crc
    input wire logic [7:0] LRC_OUT, // running lrc
    input wire logic CHK_DONE, // check compared
    input wire logic CHK_ERR // check mismatch
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    a_tail_pair: assert property (valid && tail && !$past(valid && tail) |=> valid && tail)
        else $error("tail not paired");
    a_eof_after_tail: assert property (valid && tail ##1 valid && tail |=> valid && eof && !tail)
        else $error("no eof after tail");
    a_done_on_time: assert property (valid && tail ##1 valid && tail |=> CHK_DONE)
        else $error("done missing");
    a_done_cause: assert property (CHK_DONE |-> $past(valid && tail) && $past(valid && tail, 2))
        else $error("done without check pair");
    a_err_in_done: assert property (CHK_ERR |-> CHK_DONE)
        else $error("err without done");
    a_clr_preset: assert property (CLR && !valid |=> CRC_OUT == CRC_PRESET)
        else $error("clr not preset");
    a_crc_eight_steps: assert property (valid && !tail && !eof |=> BUSY [*8] ##1 !BUSY)
        else $error("step count");
    a_crc_hold: assert property (!BUSY && !valid && !CLR |=> $stable(CRC_OUT))
        else $error("crc moved idle");
    a_lrc_add: assert property (ASCII_MODE && valid && !tail && !eof && !sof && !CLR
        |=> LRC_OUT == $past(LRC_OUT) - $past(data))
        else $error("lrc sum");
    a_lrc_start: assert property (ASCII_MODE && valid && sof && !CLR
        |=> LRC_OUT == BYTE_ZERO - $past(data))
        else $error("lrc start");
endmodule : mfc_assertions
`default_nettype wire

// ---- modbus_frame_check_unit_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("mismatch %0t %h %h", $time, a, b); end end
module modbus_frame_check_unit_tb;
    import mfc_pkg::*;
    logic clk, rst_n, mode, clr, iv, isof, ilast, ird, busy, done, err, fok, done2, err2, le, le2;
    logic [7:0] id, lrc, func;
    logic [15:0] crc, mcrc;
    logic [7:0] msg[$];
    logic [7:0] tq[$];
    int n_fail, n_tests, nd, nd2, cyc;
    mfc_if lk();
    mfc_if lk2();
    mfc_mst mfc_mst_inst(.SYS_CLK(clk), .RST_N(rst_n), .LINK(lk.mst), .ASCII_MODE(mode), .IN_VALID(iv),
        .IN_DATA(id), .IN_SOF(isof), .IN_LAST(ilast), .IN_READY(ird), .CRC_OUT(mcrc));
    mfc_dev mfc_dev_inst(.SYS_CLK(clk), .RST_N(rst_n), .LINK(lk.dev), .ASCII_MODE(mode), .CLR(clr),
        .BUSY(busy), .CRC_OUT(crc), .LRC_OUT(lrc), .CHK_DONE(done), .CHK_ERR(err), .FUNC(func), .FRAME_OK(fok));
    mfc_dev mfc_dev_inst2(.SYS_CLK(clk), .RST_N(rst_n), .LINK(lk2.dev), .ASCII_MODE(mode), .CLR(clr),
        .BUSY(), .CRC_OUT(), .LRC_OUT(), .CHK_DONE(done2), .CHK_ERR(err2), .FUNC(), .FRAME_OK());
    mfc_assertions mfc_assertions_inst(.SYS_CLK(clk), .RST_N(rst_n), .data(lk.data), .valid(lk.valid),
        .sof(lk.sof), .tail(lk.tail), .eof(lk.eof), .ASCII_MODE(mode), .CLR(clr), .BUSY(busy),
        .CRC_OUT(crc), .LRC_OUT(lrc), .CHK_DONE(done), .CHK_ERR(err));
    // ----------------------------------------------------------
    // reference arithmetic and link drivers
    // ----------------------------------------------------------
    function automatic logic [15:0] crc_ref();
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (msg[i]) begin
            c[7:0] = c[7:0] ^ msg[i];
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction : crc_ref
    function automatic logic [7:0] hx(input logic [3:0] n);
        return n < 4'hA ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction : hx
    function automatic logic [15:0] tails(input logic m);
        logic [7:0] s;
        logic [15:0] c;
        s = 8'h00;
        foreach (msg[i]) s = s + msg[i];
        s = 8'hFF - s + 8'h01;
        c = crc_ref();
        return m ? {hx(s[7:4]), hx(s[3:0])} : {c[7:0], c[15:8]};
    endfunction : tails
    task automatic finish_test();
        if (n_fail == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic frame(input logic m, input logic ok);
        logic [15:0] t;
        int k;
        int w;
        t = tails(m);
        k = nd;
        mode = m;
        tq.delete();
        for (int i = 0; i < msg.size(); i++) begin
            @(negedge clk);
            iv = 1'b1;
            id = msg[i];
            isof = (i == 0);
            ilast = (i == msg.size() - 1);
            w = 0;
            while (ird !== 1'b1 && w < 20) begin
                @(negedge clk);
                w++;
            end
            @(negedge clk);
        end
        iv = 1'b0;
        w = 0;
        while (nd == k && w < 80) begin
            @(negedge clk);
            w++;
        end
        `CHK(nd, k + 1)
        `CHK(le, 1'b0)
        `CHK(tq.size(), 2)
        `CHK({tq[0], tq[1]}, t)
        `CHK(crc, crc_ref())
        `CHK(mcrc, crc_ref())
        `CHK(func, msg[1])
        `CHK(fok, ok)
    endtask : frame
    task automatic bad(input logic m, input logic [7:0] x);
        logic [15:0] t;
        int k;
        int w;
        int n;
        t = tails(m) ^ {x, 8'h00};
        mode = m;
        n = msg.size();
        k = nd2;
        for (int i = 0; i < n + 3; i++) begin
            @(negedge clk);
            lk2.valid = 1'b1;
            lk2.sof = (i == 0);
            lk2.tail = (i >= n && i < n + 2);
            lk2.eof = (i == n + 2);
            lk2.data = i < n ? msg[i] : (i == n ? t[15:8] : t[7:0]);
            if (i < n) begin
                @(negedge clk);
                lk2.valid = 1'b0;
                repeat (8) @(negedge clk);
            end
        end
        @(negedge clk);
        lk2.valid = 1'b0;
        lk2.eof = 1'b0;
        w = 0;
        while (nd2 == k && w < 40) begin
            @(negedge clk);
            w++;
        end
        `CHK(nd2, k + 1)
        `CHK(le2, x != 8'h00)
    endtask : bad
    always @(posedge clk) begin
        cyc++;
        if (lk.valid === 1'b1 && lk.tail === 1'b1)
            tq.push_back(lk.data);
        if (done === 1'b1) begin
            nd++;
            le = err;
        end
        if (done2 === 1'b1) begin
            nd2++;
            le2 = err2;
        end
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {rst_n, mode, clr, iv, isof, ilast, id} = '0;
        {lk2.valid, lk2.sof, lk2.tail, lk2.eof, lk2.data} = '0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        msg = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02};
        frame(1'b0, 1'b0);
        `CHK({tq[1], tq[0]}, 16'h0BC4)
        bad(1'b0, 8'h01);
        frame(1'b1, 1'b0);
        bad(1'b1, 8'h02);
        bad(1'b1, 8'h00);
        msg = '{8'h01, 8'h11};
        frame(1'b0, 1'b1);
        bad(1'b0, 8'h00);
        msg = '{8'h01, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
        frame(1'b0, 1'b1);
        msg = '{8'h01, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h0A, 8'h0B};
        frame(1'b0, 1'b0);
        msg = '{8'h50, 8'h4F};
        frame(1'b1, 1'b0);
        `CHK({tq[0], tq[1]}, 16'h3631)
        @(negedge clk);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        `CHK(crc, 16'hFFFF)
        `CHK(lrc, 8'h00)
        finish_test();
    end
endmodule : modbus_frame_check_unit_tb
`default_nettype wire
